// >>> verilog/bbc_params.svh
`ifndef BBC_PARAMS_SVH
`define BBC_PARAMS_SVH
// ****************************************
// Timing constants
// ****************************************
`define BBC_CLK_MHZ        250
`define BBC_BLANK_NS       180
`define BBC_BLANK_CYC      ((`BBC_BLANK_NS * `BBC_CLK_MHZ + 999) / 1000)
`define BBC_DISCH_MS       200
`define BBC_DISCH_CYC      (`BBC_DISCH_MS * `BBC_CLK_MHZ * 1000)
`define BBC_PERIOD_CYC     625
`define BBC_OFF_CYC        16
// ****************************************
// Reset values
// ****************************************
`define BBC_OCP_RESP_RST   2'h0
`endif

// >>> verilog/bbc_pkg.sv
package bbc_pkg;
  typedef enum logic [1:0] {
    BBC_MODE_BUCK  = 2'h0,
    BBC_MODE_BOOST = 2'h1,
    BBC_MODE_BB    = 2'h3
  } bbc_mode_t;
  typedef enum logic [1:0] {
    BBC_OCP_HICCUP = 2'h0,
    BBC_OCP_LATCH  = 2'h1,
    BBC_OCP_NONE   = 2'h2
  } bbc_ocp_t;
  typedef enum logic [2:0] {
    BBC_ST_OFF    = 3'h0,
    BBC_ST_SOFT   = 3'h1,
    BBC_ST_REG    = 3'h3,
    BBC_ST_HICCUP = 3'h2,
    BBC_ST_LATCH  = 3'h6
  } bbc_state_t;
  typedef struct packed {
    logic input_high_switch;
    logic input_low_switch;
    logic output_low_switch;
    logic output_high_switch;
  } bbc_gates_t;
  typedef struct packed {
    logic fb_below_ref;
    logic fb_below_ocp;
    logic comp_trip;
    logic ss_above_ref;
    logic ss_above_fb;
    logic ss_discharged;
    logic cs_limit;
    logic avg_limit;
  } bbc_cmp_t;
endpackage : bbc_pkg

// >>> verilog/bbc_sync3.sv
`timescale 1ns/10ps
module bbc_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));
    end
  end
endmodule : bbc_sync3

// >>> verilog/bbc_switch_ctrl.sv
`timescale 1ns/10ps
`include "bbc_params.svh"
// Notes on behaviour
// (RULE1) Buck: high on at fb low, low till comp; code turns high on at period start, off at comp trip, low on until next start
// (RULE2) Boost: input high on, input low off
// (RULE3) Boost cycle: low first, then high freewheel
// (RULE4) Buck-boost: four phase switch sequence
// (RULE5) Start needs logic supply and enable bit
// (RULE6) Gate supply from lower above 8.8V
// (RULE7) Gates off on gate or boot UVLO
// (RULE8) Shutdown pulls comp low, logic off
// (RULE9) Soft start ends at ref, clamp above
// (RULE10) Pre-bias: wait until ramp exceeds feedback
// (RULE11) Soft start runs pulse-skipping mode
// (RULE12) Soft start masks hiccup and latch-off
// (RULE13) Enable level thresholds start and stop switching
// (RULE14) Defaults restored after 200ms discharge
// (RULE15) Always forced continuous conduction otherwise
// (RULE16) Buck period waits for valley current
// (RULE17) Current sense blanked 180ns after edges
// (RULE18) Current limit sets flag, alert if unmasked
// (RULE19) Hiccup: stop below 60%, retry after discharge
// (RULE20) Latch-off: stop below 60%, until toggle
// (RULE21) No response: keep switching, cycle limit
// (RULE22) Average limit pulls ramp down
// (RULE23) Response select decodes three choices
module bbc_switch_ctrl
  import bbc_pkg::*;
#(
  parameter int DISCH_CYC = `BBC_DISCH_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Supplies and enables
  input  wire logic       internal_logic_supply_ok,
  input  wire logic       gate_drive_supply_ok,
  input  wire logic       bootstrap_supply_ok,
  input  wire logic       enable_above_on,
  input  wire logic       enable_above_off,
  input  wire logic       power_enable_bit,
  input  wire logic       vin_above_8v8,
  input  wire logic       vout_above_8v8,
  input  wire logic       vin_above_vout,
  // Configuration
  input  wire bbc_mode_t  conv_mode,
  input  wire logic [1:0] overcurrent_response_select,
  input  wire logic       overcurrent_mask,
  input  wire logic       overcurrent_flag_clear,
  // Comparators
  input  wire bbc_cmp_t   cmp_in,
  // Gates and outputs
  output bbc_gates_t      gates,
  output logic            gate_supply_from_vin,
  output logic            comp_pull_low,
  output logic            ss_charge,
  output logic            ss_pull_down,
  output logic            ss_clamp_en,
  output logic            pfm_mode,
  output logic            overcurrent_flag,
  output logic            fault_alert_pin_oe,
  output logic            regs_to_default,
  output logic            interface_active
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NS = 8 + 7;
  logic [NS-1:0] raw_w;
  logic [NS-1:0] syn_w;
  assign raw_w = {cmp_in, internal_logic_supply_ok, gate_drive_supply_ok,
                  bootstrap_supply_ok, enable_above_on, enable_above_off,
                  vin_above_8v8, vout_above_8v8};
  bbc_sync3 #(.W(NS)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (raw_w),
    .q     (syn_w)
  );
  bbc_cmp_t cmp_w;
  logic     logic_ok_w;
  logic     gate_ok_w;
  logic     boot_ok_w;
  logic     en_on_w;
  logic     en_off_w;
  logic     vin_hi_w;
  logic     vout_hi_w;
  assign {cmp_w, logic_ok_w, gate_ok_w, boot_ok_w, en_on_w, en_off_w,
          vin_hi_w, vout_hi_w} = syn_w;

  // ****************************************
  // Enable level with hysteresis
  // ****************************************
  logic en_reg;
  // (RULE13) Enable hysteresis
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_reg <= 1'b0;
    end else if (en_on_w) begin
      en_reg <= 1'b1;
    end else if (!en_off_w) begin
      en_reg <= 1'b0;
    end
  end
  logic run_w;
  // (RULE5) Start gating
  assign run_w = en_reg && logic_ok_w && power_enable_bit;

  // ****************************************
  // Overcurrent response decode
  // ****************************************
  function automatic bbc_ocp_t decode_ocp(input logic [1:0] sel);
    case (sel)
      2'h0:    decode_ocp = BBC_OCP_HICCUP;
      2'h1:    decode_ocp = BBC_OCP_LATCH;
      default: decode_ocp = BBC_OCP_NONE;
    endcase
  endfunction : decode_ocp
  bbc_ocp_t ocp_w;
  // (RULE23) Response decode
  assign ocp_w = decode_ocp(overcurrent_response_select);

  // ****************************************
  // Protection state machine
  // ****************************************
  bbc_state_t state_reg;
  logic       ss_done_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= BBC_ST_OFF;
    end else if (!run_w) begin
      // (RULE20) Toggle releases latch
      state_reg <= BBC_ST_OFF;
    end else begin
      case (state_reg)
        BBC_ST_OFF:    state_reg <= BBC_ST_SOFT;
        // (RULE9) End soft start
        BBC_ST_SOFT:   if (cmp_w.ss_above_ref) state_reg <= BBC_ST_REG;
        BBC_ST_REG: begin
          // (RULE12) Masked in soft start
          if (cmp_w.fb_below_ocp && ocp_w == BBC_OCP_HICCUP) begin
            state_reg <= BBC_ST_HICCUP;
          end else if (cmp_w.fb_below_ocp && ocp_w == BBC_OCP_LATCH) begin
            state_reg <= BBC_ST_LATCH;
          end
        end
        // (RULE19) Retry after discharge
        BBC_ST_HICCUP: if (cmp_w.ss_discharged) state_reg <= BBC_ST_SOFT;
        BBC_ST_LATCH:  state_reg <= BBC_ST_LATCH;
        default:       state_reg <= BBC_ST_OFF;
      endcase
    end
  end
  logic active_w;
  logic prebias_w;
  assign active_w  = state_reg == BBC_ST_SOFT || state_reg == BBC_ST_REG;
  // (RULE10) Pre-bias hold
  assign prebias_w = state_reg == BBC_ST_SOFT && !cmp_w.ss_above_fb;

  // ****************************************
  // Period counter and blanking
  // ****************************************
  logic [9:0] per_reg;
  logic [2:0] phase_reg;
  logic       on_reg;
  logic [7:0] blank_reg;
  logic       edge_w;
  logic       start_w;
  logic       cs_w;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      per_reg <= 10'h000;
    end else if (!active_w || per_reg == 10'(`BBC_PERIOD_CYC - 1)) begin
      per_reg <= 10'h000;
    end else begin
      per_reg <= per_reg + 10'h001;
    end
  end
  // (RULE17) Sense blanking
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blank_reg <= 8'h00;
    end else if (edge_w) begin
      blank_reg <= 8'(`BBC_BLANK_CYC);
    end else if (blank_reg != 8'h00) begin
      blank_reg <= blank_reg - 8'h01;
    end
  end
  assign cs_w = cmp_w.cs_limit && blank_reg == 8'h00;
  // (RULE16) Valley wait in buck
  // (RULE11) Pulses only on demand
  assign start_w = per_reg == 10'h000 && active_w && !prebias_w &&
                   !(conv_mode == BBC_MODE_BUCK && cs_w) &&
                   !(state_reg == BBC_ST_SOFT && !cmp_w.fb_below_ref);

  // ****************************************
  // Switch phase sequencing
  // ****************************************
  bbc_gates_t g_next;
  logic       trip_prev_reg;
  logic       trip_w;
  // Comparator rising edge; boost also trips on current limit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trip_prev_reg <= 1'b0;
    end else begin
      trip_prev_reg <= cmp_w.comp_trip;
    end
  end
  assign trip_w = (cmp_w.comp_trip && !trip_prev_reg) ||
                  (conv_mode == BBC_MODE_BOOST && cs_w);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      on_reg    <= 1'b0;
      phase_reg <= 3'h0;
    end else if (!active_w) begin
      on_reg    <= 1'b0;
      phase_reg <= 3'h0;
    end else if (start_w) begin
      on_reg    <= 1'b1;
      phase_reg <= 3'h0;
    // (RULE4) Phase steps per trip
    end else if (trip_w && (on_reg || (conv_mode == BBC_MODE_BB && phase_reg != 3'h3))) begin
      on_reg    <= 1'b0;
      phase_reg <= (phase_reg == 3'h3) ? 3'h3 : phase_reg + 3'h1;
    end
  end
  always_comb begin
    g_next = '0;
    case (conv_mode)
      // (RULE1) Buck switching
      BBC_MODE_BUCK: begin
        g_next.input_high_switch  = on_reg;
        g_next.input_low_switch   = !on_reg;
        g_next.output_high_switch = 1'b1;
      end
      // (RULE2) Boost switching
      // (RULE3) Boost freewheel
      BBC_MODE_BOOST: begin
        g_next.input_high_switch  = 1'b1;
        g_next.output_low_switch  = on_reg;
        g_next.output_high_switch = !on_reg;
      end
      // (RULE4) Four phase sequence
      BBC_MODE_BB: begin
        g_next.input_high_switch  = phase_reg != 3'h3;
        g_next.input_low_switch   = phase_reg == 3'h3;
        g_next.output_low_switch  = phase_reg == 3'h1;
        g_next.output_high_switch = phase_reg != 3'h1;
      end
      default: g_next = '0;
    endcase
    // (RULE15) Continuous conduction kept
    // (RULE7) Gates off on UVLO
    if (!active_w || !gate_ok_w || !boot_ok_w || prebias_w) begin
      g_next = '0;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gates <= '0;
    end else begin
      gates <= g_next;
    end
  end
  assign edge_w = g_next != gates;

  // ****************************************
  // Overcurrent flag and alert
  // ****************************************
  // (RULE18) Flag set wins
  // (RULE21) Cycle limit only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overcurrent_flag   <= 1'b0;
      fault_alert_pin_oe <= 1'b0;
    end else begin
      overcurrent_flag   <= (cs_w && active_w) ||
                            (overcurrent_flag && !overcurrent_flag_clear && run_w);
      fault_alert_pin_oe <= ((cs_w && active_w) || overcurrent_flag) &&
                            !overcurrent_mask && run_w;
    end
  end

  // ****************************************
  // Supply, ramp and shutdown outputs
  // ****************************************
  logic [27:0] disch_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      disch_reg <= 28'h0000000;
    end else if (en_reg) begin
      disch_reg <= 28'h0000000;
    end else if (disch_reg != 28'(DISCH_CYC)) begin
      disch_reg <= disch_reg + 28'h0000001;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_supply_from_vin <= 1'b1;
      comp_pull_low        <= 1'b1;
      ss_charge            <= 1'b0;
      ss_pull_down         <= 1'b0;
      ss_clamp_en          <= 1'b0;
      pfm_mode             <= 1'b0;
      regs_to_default      <= 1'b1;
      interface_active     <= 1'b0;
    end else begin
      // (RULE6) Gate supply source
      gate_supply_from_vin <= (vin_hi_w && vout_hi_w) ? !vin_above_vout : vin_above_vout;
      // (RULE8) Shutdown comp pull
      comp_pull_low        <= !(en_reg && logic_ok_w) || !active_w;
      interface_active     <= en_reg && logic_ok_w;
      ss_charge            <= active_w;
      // (RULE22) Average limit pulldown
      ss_pull_down         <= active_w && cmp_w.avg_limit;
      // (RULE9) Ramp clamp
      ss_clamp_en          <= state_reg == BBC_ST_REG;
      pfm_mode             <= state_reg == BBC_ST_SOFT;
      // (RULE14) Defaults after discharge
      regs_to_default      <= disch_reg == 28'(DISCH_CYC);
    end
  end
endmodule : bbc_switch_ctrl

// >>> bench/bbc_checker.sv
`timescale 1ns/10ps
module bbc_checker
  import bbc_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Inputs
  input wire logic       internal_logic_supply_ok,
  input wire logic       gate_drive_supply_ok,
  input wire logic       power_enable_bit,
  input wire logic       vin_above_8v8,
  input wire logic       vout_above_8v8,
  input wire logic       vin_above_vout,
  input wire bbc_mode_t  conv_mode,
  input wire logic       overcurrent_mask,
  // Outputs
  input wire bbc_gates_t gates,
  input wire logic       gate_supply_from_vin,
  input wire logic       comp_pull_low,
  input wire logic       overcurrent_flag,
  input wire logic       fault_alert_pin_oe,
  input wire logic       interface_active
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic both_hi;
  assign both_hi = vin_above_8v8 && vout_above_8v8;
  buck_path_a: assert property (
    conv_mode == BBC_MODE_BUCK [*4] |-> !gates.output_low_switch)
    else $error("output low switch on in buck");
  boost_path_a: assert property (
    conv_mode == BBC_MODE_BOOST [*4] |-> !gates.input_low_switch)
    else $error("input low switch on in boost");
  start_gate_a: assert property (
    !power_enable_bit [*4] |-> gates == '0)
    else $error("switching without enable bit");
  supply_low_a: assert property (
    (both_hi && vin_above_vout) [*8] |-> !gate_supply_from_vin)
    else $error("gate supply not from lower source");
  supply_high_a: assert property (
    (!both_hi && vin_above_vout) [*8] |-> gate_supply_from_vin)
    else $error("gate supply not from higher source");
  gate_uvlo_a: assert property (
    !gate_drive_supply_ok [*8] |-> gates == '0)
    else $error("gates on under gate supply lockout");
  logic_off_a: assert property (
    !internal_logic_supply_ok [*8] |-> comp_pull_low && !interface_active)
    else $error("logic still active under lockout");
  sense_blank_a: assert property (
    $changed(gates) |=> (!$rose(overcurrent_flag)) [*8])
    else $error("current limit seen inside blanking");
  alert_raise_a: assert property (
    $rose(overcurrent_flag) && !overcurrent_mask |-> fault_alert_pin_oe)
    else $error("alert missing with flag unmasked");
  alert_mask_a: assert property (
    overcurrent_mask [*3] |-> !fault_alert_pin_oe)
    else $error("alert driven while masked");
endmodule : bbc_checker
bind bbc_switch_ctrl bbc_checker bbc_checker_i (.*);

// >>> bench/bbc_stage_model.sv
`timescale 1ns/10ps
module bbc_stage_model
  import bbc_pkg::*;
#(
  parameter int ON  = 30,
  parameter int FBV = 20,
  parameter int REF = 40
) (
  // Clock
  input  wire logic       clock,
  // Gate drive and soft-start pin
  input  wire bbc_gates_t gates,
  input  wire logic       ss_charge,
  input  wire logic       ss_pull_down,
  // Load conditions
  input  wire logic       fb_low,
  input  wire logic       fb_ocp,
  input  wire logic       oc,
  input  wire logic       avg,
  // Comparator levels
  output bbc_cmp_t        cmp_in
);
  bbc_gates_t g_q  = '0;
  int         on_q = 0;
  int         ss_q = 0;
  // Inductor ramp since last edge
  always_ff @(posedge clock) begin
    g_q  <= gates;
    on_q <= (gates != g_q) ? 0 : on_q + 1;
  end
  // Soft-start capacitor
  always_ff @(posedge clock) begin
    if (ss_pull_down || !ss_charge)
      ss_q <= (ss_q > 0) ? ss_q - 1 : 0;
    else
      ss_q <= (ss_q < REF + 10) ? ss_q + 1 : ss_q;
  end
  assign cmp_in = '{fb_low, fb_ocp, on_q >= ON, ss_q >= REF, ss_q > FBV, ss_q == 0, oc, avg};
endmodule : bbc_stage_model

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import bbc_pkg::*;
  localparam logic [3:0] BB_SEQ [4] = '{4'h9, 4'ha, 4'h9, 4'h5};
  logic clock = 1'b0, rst = 1'b1, power_enable_bit = 1'b0;
  logic internal_logic_supply_ok = 1'b1, gate_drive_supply_ok = 1'b1;
  logic bootstrap_supply_ok = 1'b1, enable_above_on = 1'b1, enable_above_off = 1'b1;
  logic vin_above_8v8 = 1'b0, vout_above_8v8 = 1'b0, vin_above_vout = 1'b0;
  bbc_mode_t conv_mode = BBC_MODE_BUCK;
  logic [1:0] overcurrent_response_select = 2'h2, seen;
  logic overcurrent_mask = 1'b0, overcurrent_flag_clear = 1'b0;
  logic fb_low = 1'b1, fb_ocp = 1'b0, oc = 1'b0, avg = 1'b0;
  bbc_cmp_t cmp_in;
  bbc_gates_t gates, last;
  logic gate_supply_from_vin, comp_pull_low, ss_charge, ss_pull_down, ss_clamp_en;
  logic pfm_mode, overcurrent_flag, fault_alert_pin_oe, regs_to_default, interface_active;
  int err_total = 0, n_tests = 0;
  always #2 clock = ~clock;
  bbc_switch_ctrl #(.DISCH_CYC(100)) bbc_switch_ctrl_i (.*);
  bbc_stage_model bbc_stage_model_i (.*);
  // ****
  // Helpers
  // ****
  function automatic logic exp_gsv(input logic a, input logic b, input logic g);
    return (a && b) ? !g : g;
  endfunction : exp_gsv
  function automatic logic [1:0] exp_resp(input int s);
    return (s == 0) ? 2'h3 : (s == 1) ? 2'h0 : 2'h1;
  endfunction : exp_resp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic restart;
    @(posedge clock);
    power_enable_bit <= 1'b0;
    overcurrent_flag_clear <= 1'b0;
    cyc(80);
    @(posedge clock);
    power_enable_bit <= 1'b1;
    cyc(8);
    chk(gates, 4'h0);
    chk(pfm_mode, 1'b1);
    for (int i = 0; i < 400 && pfm_mode !== 1'b0; i++) cyc(1);
    chk({pfm_mode, ss_clamp_en}, 2'h1);
    $display("test start finished");
  endtask : restart
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(32'h750f90ea));
    cyc(8);
    chk({comp_pull_low, gate_supply_from_vin, regs_to_default, interface_active}, 4'he);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      {vin_above_8v8, vout_above_8v8, vin_above_vout} <= 3'($urandom);
      cyc(9);
      chk(gate_supply_from_vin, exp_gsv(vin_above_8v8, vout_above_8v8, vin_above_vout));
    end
    restart();
    for (int i = 0; i < 700 && gates.input_high_switch !== 1'b1; i++) cyc(1);
    chk(gates, 4'h9);
    for (int i = 0; i < 100 && gates.input_low_switch !== 1'b1; i++) cyc(1);
    chk(gates, 4'h5);
    @(posedge clock);
    conv_mode <= BBC_MODE_BOOST;
    for (int i = 0; i < 1400 && gates !== 4'ha; i++) cyc(1);
    chk(gates, 4'ha);
    for (int i = 0; i < 100 && gates.output_high_switch !== 1'b1; i++) cyc(1);
    chk(gates, 4'h9);
    @(posedge clock);
    conv_mode <= BBC_MODE_BB;
    for (int i = 0; i < 3000 && gates !== 4'h5; i++) cyc(1);
    for (int k = 0; k < 4; k++) begin
      last = gates;
      for (int i = 0; i < 800 && gates === last; i++) cyc(1);
      chk(gates, BB_SEQ[k]);
    end
    $display("test modes finished");
    @(posedge clock);
    conv_mode <= BBC_MODE_BUCK;
    oc <= 1'b1;
    cyc(700);
    chk({overcurrent_flag, fault_alert_pin_oe}, 2'h3);
    chk(gates, 4'h5);
    @(posedge clock);
    overcurrent_mask <= 1'b1;
    cyc(3);
    chk({overcurrent_flag, fault_alert_pin_oe}, 2'h2);
    @(posedge clock);
    oc <= 1'b0;
    overcurrent_flag_clear <= 1'b1;
    cyc(8);
    chk(overcurrent_flag, 1'b0);
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      overcurrent_response_select <= 2'(s);
      fb_ocp <= 1'b0;
      restart();
      @(posedge clock);
      fb_ocp <= 1'b1;
      cyc(30);
      if (s < 2) chk(gates, 4'h0);
      seen = 2'h0;
      repeat (300) begin
        cyc(1);
        seen = seen | {pfm_mode, gates != 4'h0};
      end
      chk(seen, exp_resp(s));
    end
    $display("test protection finished");
    @(posedge clock);
    avg <= 1'b1;
    cyc(8);
    chk({ss_charge, ss_pull_down}, 2'h3);
    @(posedge clock);
    avg <= 1'b0;
    fb_ocp <= 1'b0;
    internal_logic_supply_ok <= 1'b0;
    cyc(10);
    chk({comp_pull_low, interface_active, ss_charge, ss_pull_down, gates}, 8'h80);
    @(posedge clock);
    internal_logic_supply_ok <= 1'b1;
    restart();
    @(posedge clock);
    gate_drive_supply_ok <= 1'b0;
    cyc(10);
    chk(gates, 4'h0);
    @(posedge clock);
    gate_drive_supply_ok <= 1'b1;
    bootstrap_supply_ok <= 1'b0;
    cyc(10);
    chk(gates, 4'h0);
    @(posedge clock);
    bootstrap_supply_ok <= 1'b1;
    {enable_above_on, enable_above_off} <= 2'h0;
    cyc(60);
    chk(regs_to_default, 1'b0);
    cyc(60);
    chk(regs_to_default, 1'b1);
    @(posedge clock);
    enable_above_off <= 1'b1;
    cyc(60);
    chk(pfm_mode, 1'b0);
    @(posedge clock);
    enable_above_on <= 1'b1;
    cyc(20);
    chk(pfm_mode, 1'b1);
    $display("test shutdown finished");
    results();
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    results();
  end
endmodule : tb_top
